/* File: core/rtcpit_defines.svh */
// register indices, field positions, reset values and timing counts
`ifndef RTCPIT_DEFINES_SVH
`define RTCPIT_DEFINES_SVH

// register indices; byte address is four times the index
`define RTCPIT_IDX_CTRL      6'h00
`define RTCPIT_IDX_STATUS    6'h01
`define RTCPIT_IDX_IRQEN     6'h02
`define RTCPIT_IDX_FLAGS     6'h03
`define RTCPIT_IDX_TEMP      6'h04
`define RTCPIT_IDX_DBG       6'h05
`define RTCPIT_IDX_SRC       6'h07
`define RTCPIT_IDX_CNT       6'h08
`define RTCPIT_IDX_TOP       6'h0A
`define RTCPIT_IDX_CMP       6'h0C
`define RTCPIT_IDX_PCTRL     6'h10
`define RTCPIT_IDX_PSTATUS   6'h11
`define RTCPIT_IDX_PIRQEN    6'h12
`define RTCPIT_IDX_PFLAG     6'h13
`define RTCPIT_IDX_PDBG      6'h15

// primary_control fields
`define RTCPIT_CTRL_ON_BIT   0
`define RTCPIT_PRESC_LSB     3
`define RTCPIT_PRESC_MSB     6
`define RTCPIT_STDBY_BIT     7
`define RTCPIT_CTRL_WMASK    8'hF9
// interval_control fields
`define RTCPIT_PIT_ON_BIT    0
`define RTCPIT_PERIOD_LSB    3
`define RTCPIT_PERIOD_MSB    6
`define RTCPIT_PCTRL_WMASK   8'h79
// flag and enable bits
`define RTCPIT_WRAP_BIT      0
`define RTCPIT_MATCH_BIT     1
`define RTCPIT_PI_BIT        0
`define RTCPIT_DBG_BIT       0
`define RTCPIT_IRQEN_WMASK   8'h03
`define RTCPIT_ONEBIT_WMASK  8'h01
`define RTCPIT_SRC_WMASK     8'h03
// sync status bits; also the index of each pending write
`define RTCPIT_PEND_CTRL     0
`define RTCPIT_PEND_CNT      1
`define RTCPIT_PEND_TOP      2
`define RTCPIT_PEND_CMP      3
`define RTCPIT_PEND_PIT      4
`define RTCPIT_PEND_N        5

// reset values
`define RTCPIT_BYTE_RST      8'h00
`define RTCPIT_WORD_RST      16'h0000
`define RTCPIT_TOP_RST       16'hFFFF

// timing
`define RTCPIT_SYNC_TICKS    2'd2
`define RTCPIT_DIV1K_LAST    5'h1F
`define RTCPIT_EV0_LOG2      13
`define RTCPIT_NUM_EVENTS    8

`endif

/* File: core/rtcpit_pkg.sv */
// types shared by the counter and interval timer block
package rtcpit_pkg;

  typedef enum logic [1:0] {
    RTCPIT_ACTIVE,
    RTCPIT_IDLE,
    RTCPIT_STANDBY
  } rtcpit_sleep_t;

  typedef enum logic [1:0] {
    RTCPIT_SRC_OSC32K,
    RTCPIT_SRC_OSC1K,
    RTCPIT_SRC_RESERVED,
    RTCPIT_SRC_EXT
  } rtcpit_src_t;

endpackage

/* File: core/rtcpit_sync.sv */
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module rtcpit_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      rise
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // edge detect looks only at the second and third flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign rise = sync_r & ~last_r;
endmodule

/* File: core/rtcpit_top.sv */
// real-time counter with periodic interval timer behind an apb slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`include "rtcpit_defines.svh"

// Operation
// - one selected slow clock drives both functions
// - counter runs while counter_on is one
// - interval timer runs while its on bit set
// - wrap event when counter passes top value
// - match event when counter equals match value
// - eight taps pulse every 8192 down to 64
// - counter irq and periodic irq are separate
// - periodic flag set when chosen period elapses
// - flags set regardless of enable bits
// - irq stays asserted while flag and enable set
// - standby stops counter unless keep running bit
// - interval timer runs in every sleep mode
// - writes reach slow side after slow ticks
// - status shows per-register sync pending bits
// - interval status shows control sync pending
// - counter returns to zero after top value
// - prescaler divides by two to the field
// - source field selects 32k, 1k or pin
// - writing one clears a flag, zero keeps it
module rtcpit_top #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 15
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  low_power_oscillator_clk,
  input  wire logic                  ext_clk_pin,
  input  wire rtcpit_pkg::rtcpit_sleep_t sleep_mode,
  input  wire logic                  cpu_halted,
  output logic                       counter_irq,
  output logic                       periodic_irq,
  output logic                       wrap_event,
  output logic                       match_event,
  output logic [7:0]                 interval_event
);
  import rtcpit_pkg::*;

  // true when n is at most PSC_W and the low n bits of the prescaler are all ones
  function automatic logic psc_tap(input logic [PSC_W-1:0] v,
                                   input int               n);
    logic r;
    r = (n <= PSC_W);
    for (int i = 0; i < PSC_W; i++) begin
      if (i < n && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  logic [5:0]             idx;
  logic                   setup;
  logic                   wr_en;
  logic                   mapped;
  logic [31:0]            rd_val;
  logic [31:0]            prdata_r;
  logic [7:0]             wbyte;

  logic [7:0]             ctrl_sw_r;
  logic [7:0]             ctrl_act_r;
  logic [CNT_W-1:0]       cnt_sw_r;
  logic [CNT_W-1:0]       top_sw_r;
  logic [CNT_W-1:0]       top_act_r;
  logic [CNT_W-1:0]       cmp_sw_r;
  logic [CNT_W-1:0]       cmp_act_r;
  logic [7:0]             pit_sw_r;
  logic [7:0]             pit_act_r;
  logic [1:0]             irq_en_r;
  logic [1:0]             flags_r;
  logic                   pit_en_r;
  logic                   pit_flag_r;
  logic [7:0]             temp_r;
  logic                   dbg_r;
  logic                   pit_dbg_r;
  logic [1:0]             src_r;

  logic [`RTCPIT_PEND_N-1:0] pend_r;
  logic [`RTCPIT_PEND_N-1:0] wr_hit;
  logic [`RTCPIT_PEND_N-1:0] apply;
  logic [1:0]             age_r [`RTCPIT_PEND_N];

  logic                   osc_rise;
  logic                   ext_rise;
  logic [4:0]             div_r;
  logic                   slow_tick;
  logic [PSC_W-1:0]       psc_r;
  logic [CNT_W-1:0]       count_r;
  logic                   counter_run;
  logic                   pit_run;
  logic                   cnt_tick;
  logic                   wrap_hit;
  logic                   match_hit;
  logic                   pit_hit;
  logic [3:0]             presc;
  logic [3:0]             period;
  logic                   wrap_event_r;
  logic                   match_event_r;
  logic [7:0]             interval_event_r;

  // ---------------- apb slave ----------------
  assign idx    = paddr[7:2];
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;
  assign wbyte  = pwdata[7:0];
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (idx)
      `RTCPIT_IDX_CTRL:    rd_val[7:0] = ctrl_sw_r;
      `RTCPIT_IDX_STATUS:  rd_val[3:0] = pend_r[3:0];
      `RTCPIT_IDX_IRQEN:   rd_val[1:0] = irq_en_r;
      `RTCPIT_IDX_FLAGS:   rd_val[1:0] = flags_r;
      `RTCPIT_IDX_TEMP:    rd_val[7:0] = temp_r;
      `RTCPIT_IDX_DBG:     rd_val[0]   = dbg_r;
      `RTCPIT_IDX_SRC:     rd_val[1:0] = src_r;
      `RTCPIT_IDX_CNT:     rd_val[CNT_W-1:0] = count_r;
      `RTCPIT_IDX_TOP:     rd_val[CNT_W-1:0] = top_sw_r;
      `RTCPIT_IDX_CMP:     rd_val[CNT_W-1:0] = cmp_sw_r;
      `RTCPIT_IDX_PCTRL:   rd_val[7:0] = pit_sw_r;
      `RTCPIT_IDX_PSTATUS: rd_val[0]   = pend_r[`RTCPIT_PEND_PIT];
      `RTCPIT_IDX_PIRQEN:  rd_val[0]   = pit_en_r;
      `RTCPIT_IDX_PFLAG:   rd_val[0]   = pit_flag_r;
      `RTCPIT_IDX_PDBG:    rd_val[0]   = pit_dbg_r;
      default:             mapped      = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = psel & penable & ~mapped;

  // plain control registers, effective at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r  <= 2'b00;
      pit_en_r  <= 1'b0;
      temp_r    <= `RTCPIT_BYTE_RST;
      dbg_r     <= 1'b0;
      pit_dbg_r <= 1'b0;
      src_r     <= 2'b00;
    end else if (wr_en) begin
      case (idx)
        `RTCPIT_IDX_IRQEN: irq_en_r  <= wbyte[1:0];
        `RTCPIT_IDX_PIRQEN: pit_en_r <= wbyte[`RTCPIT_PI_BIT];
        `RTCPIT_IDX_TEMP:  temp_r    <= wbyte;
        `RTCPIT_IDX_DBG:   dbg_r     <= wbyte[`RTCPIT_DBG_BIT];
        `RTCPIT_IDX_PDBG:  pit_dbg_r <= wbyte[`RTCPIT_DBG_BIT];
        `RTCPIT_IDX_SRC:   src_r     <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // ---------------- writes crossing to the slow side ----------------
  always_comb begin
    wr_hit = '0;
    if (wr_en) begin
      wr_hit[`RTCPIT_PEND_CTRL] = (idx == `RTCPIT_IDX_CTRL);
      wr_hit[`RTCPIT_PEND_CNT]  = (idx == `RTCPIT_IDX_CNT);
      wr_hit[`RTCPIT_PEND_TOP]  = (idx == `RTCPIT_IDX_TOP);
      wr_hit[`RTCPIT_PEND_CMP]  = (idx == `RTCPIT_IDX_CMP);
      wr_hit[`RTCPIT_PEND_PIT]  = (idx == `RTCPIT_IDX_PCTRL);
    end
  end

  // software-visible copies take the written value immediately
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw_r <= `RTCPIT_BYTE_RST;
      cnt_sw_r  <= `RTCPIT_WORD_RST;
      top_sw_r  <= `RTCPIT_TOP_RST;
      cmp_sw_r  <= `RTCPIT_WORD_RST;
      pit_sw_r  <= `RTCPIT_BYTE_RST;
    end else begin
      if (wr_hit[`RTCPIT_PEND_CTRL]) begin
        ctrl_sw_r <= wbyte & `RTCPIT_CTRL_WMASK;
      end
      if (wr_hit[`RTCPIT_PEND_CNT]) begin
        cnt_sw_r <= pwdata[CNT_W-1:0];
      end
      if (wr_hit[`RTCPIT_PEND_TOP]) begin
        top_sw_r <= pwdata[CNT_W-1:0];
      end
      if (wr_hit[`RTCPIT_PEND_CMP]) begin
        cmp_sw_r <= pwdata[CNT_W-1:0];
      end
      if (wr_hit[`RTCPIT_PEND_PIT]) begin
        pit_sw_r <= wbyte & `RTCPIT_PCTRL_WMASK;
      end
    end
  end

  // a rewrite while pending restarts the wait; without slow ticks the
  // pending bit never clears, which is the cue that no source is running
  always_comb begin
    for (int k = 0; k < `RTCPIT_PEND_N; k++) begin
      apply[k] = pend_r[k] & slow_tick &
                 (age_r[k] == `RTCPIT_SYNC_TICKS - 2'd1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
      for (int k = 0; k < `RTCPIT_PEND_N; k++) begin
        age_r[k] <= 2'd0;
      end
    end else begin
      for (int k = 0; k < `RTCPIT_PEND_N; k++) begin
        if (wr_hit[k]) begin
          pend_r[k] <= 1'b1;
          age_r[k]  <= 2'd0;
        end else if (apply[k]) begin
          pend_r[k] <= 1'b0;
        end else if (pend_r[k] && slow_tick) begin
          age_r[k]  <= age_r[k] + 2'd1;
        end
      end
    end
  end

  // slow-side copies, loaded two slow ticks after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_act_r <= `RTCPIT_BYTE_RST;
      top_act_r  <= `RTCPIT_TOP_RST;
      cmp_act_r  <= `RTCPIT_WORD_RST;
      pit_act_r  <= `RTCPIT_BYTE_RST;
    end else begin
      if (apply[`RTCPIT_PEND_CTRL]) begin
        ctrl_act_r <= ctrl_sw_r;
      end
      if (apply[`RTCPIT_PEND_TOP]) begin
        top_act_r <= top_sw_r;
      end
      if (apply[`RTCPIT_PEND_CMP]) begin
        cmp_act_r <= cmp_sw_r;
      end
      if (apply[`RTCPIT_PEND_PIT]) begin
        pit_act_r <= pit_sw_r;
      end
    end
  end

  // ---------------- slow clock source ----------------
  rtcpit_sync u_osc_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (low_power_oscillator_clk),
    .rise     (osc_rise)
  );

  rtcpit_sync u_ext_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_clk_pin),
    .rise     (ext_rise)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 5'h00;
    end else if (osc_rise) begin
      div_r <= div_r + 5'h01;
    end
  end

  // the pin source only works while pclk is well above the pin rate
  always_comb begin
    case (rtcpit_src_t'(src_r))
      RTCPIT_SRC_OSC32K: slow_tick = osc_rise;
      RTCPIT_SRC_OSC1K:  slow_tick = osc_rise &
                                     (div_r == `RTCPIT_DIV1K_LAST);
      RTCPIT_SRC_EXT:    slow_tick = ext_rise;
      default:           slow_tick = 1'b0;
    endcase
  end

  // one free-running prescaler serves both functions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_r <= '0;
    end else if (slow_tick) begin
      psc_r <= psc_r + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------- counter ----------------
  assign presc = ctrl_act_r[`RTCPIT_PRESC_MSB:`RTCPIT_PRESC_LSB];

  always_comb begin
    counter_run = ctrl_act_r[`RTCPIT_CTRL_ON_BIT];
    case (sleep_mode)
      RTCPIT_ACTIVE:  ;
      RTCPIT_IDLE:    ;
      RTCPIT_STANDBY: counter_run = counter_run &
                                    ctrl_act_r[`RTCPIT_STDBY_BIT];
      default:        ;
    endcase
    if (cpu_halted && !dbg_r) begin
      counter_run = 1'b0;
    end
  end

  assign cnt_tick  = slow_tick & counter_run &
                     psc_tap(psc_r, int'(presc));
  assign wrap_hit  = cnt_tick & ~apply[`RTCPIT_PEND_CNT] &
                     (count_r == top_act_r);
  assign match_hit = cnt_tick & ~apply[`RTCPIT_PEND_CNT] &
                     (count_r == cmp_act_r);

  // a synchronised count write wins over the tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `RTCPIT_WORD_RST;
    end else if (apply[`RTCPIT_PEND_CNT]) begin
      count_r <= cnt_sw_r;
    end else if (wrap_hit) begin
      count_r <= '0;
    end else if (cnt_tick) begin
      count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------- interval timer ----------------
  // sleep mode is not looked at: this runs in all of them
  assign pit_run = pit_act_r[`RTCPIT_PIT_ON_BIT] &
                   ~(cpu_halted & ~pit_dbg_r);
  assign period  = pit_act_r[`RTCPIT_PERIOD_MSB:`RTCPIT_PERIOD_LSB];
  assign pit_hit = slow_tick & pit_run & (period != 4'h0) &
                   psc_tap(psc_r, int'(period) + 1);

  // ---------------- events ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_event_r     <= 1'b0;
      match_event_r    <= 1'b0;
      interval_event_r <= 8'h00;
    end else begin
      wrap_event_r  <= wrap_hit;
      match_event_r <= match_hit;
      for (int i = 0; i < `RTCPIT_NUM_EVENTS; i++) begin
        interval_event_r[i] <= slow_tick & pit_run &
          psc_tap(psc_r, `RTCPIT_EV0_LOG2 - i);
      end
    end
  end

  assign wrap_event     = wrap_event_r;
  assign match_event    = match_event_r;
  assign interval_event = interval_event_r;

  // ---------------- flags and interrupts ----------------
  // a new event beats a clear written in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r    <= 2'b00;
      pit_flag_r <= 1'b0;
    end else begin
      flags_r[`RTCPIT_WRAP_BIT] <= wrap_hit |
        (flags_r[`RTCPIT_WRAP_BIT] &
         ~(wr_en && idx == `RTCPIT_IDX_FLAGS &&
           wbyte[`RTCPIT_WRAP_BIT]));
      flags_r[`RTCPIT_MATCH_BIT] <= match_hit |
        (flags_r[`RTCPIT_MATCH_BIT] &
         ~(wr_en && idx == `RTCPIT_IDX_FLAGS &&
           wbyte[`RTCPIT_MATCH_BIT]));
      pit_flag_r <= pit_hit |
        (pit_flag_r &
         ~(wr_en && idx == `RTCPIT_IDX_PFLAG &&
           wbyte[`RTCPIT_PI_BIT]));
    end
  end

  // two separate request lines, one per vector
  assign counter_irq  = |(flags_r & irq_en_r);
  assign periodic_irq = pit_flag_r & pit_en_r;

endmodule

/* File: tb/rtcpit_top_chk.sv */
// concurrent checks on the interrupt and event outputs of the rtc block
`timescale 1ns/1ns
`include "rtcpit_defines.svh"
module rtcpit_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        counter_irq,
  input wire logic        periodic_irq,
  input wire logic        wrap_event,
  input wire logic        match_event,
  input wire logic [7:0]  interval_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] idx;
  logic       acc_w;
  logic       cw_acc;
  logic       pw_acc;
  logic       ev_any;
  logic [9:0] gap_r;
  assign idx    = paddr[7:2];
  assign acc_w  = psel && penable && pwrite;
  assign cw_acc = acc_w &&
    (idx == `RTCPIT_IDX_IRQEN || idx == `RTCPIT_IDX_FLAGS);
  assign pw_acc = acc_w &&
    (idx == `RTCPIT_IDX_PIRQEN || idx == `RTCPIT_IDX_PFLAG);
  assign ev_any = wrap_event || match_event;
  // saturates so the first tap after reset never looks too close
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 10'h3FF;
    end else if (interval_event[7]) begin
      gap_r <= 10'h000;
    end else if (gap_r != 10'h3FF) begin
      gap_r <= gap_r + 10'h001;
    end
  end
  sequence s_clr_both;
    psel && !penable && pwrite && idx == `RTCPIT_IDX_FLAGS &&
      pwdata[1:0] == 2'h3 ##1 psel && penable;
  endsequence
  a_wrap_pulse: assert property (wrap_event |=> !wrap_event)
    else $error("wrap event wider than one cycle");
  a_match_pulse: assert property (match_event |=> !match_event)
    else $error("match event wider than one cycle");
  a_taps_nested: assert property (interval_event |->
    (interval_event[6:0] & ~interval_event[7:1]) == 7'h00)
    else $error("slow tap fired without the faster tap");
  a_tap_spacing: assert property (interval_event[7] |->
    gap_r >= 10'h0FA)
    else $error("fastest tap repeated too soon");
  a_cirq_cause: assert property ($rose(counter_irq) |->
    ev_any || $past(cw_acc))
    else $error("counter irq rose without a cause");
  a_cirq_hold: assert property ($fell(counter_irq) |->
    $past(cw_acc))
    else $error("counter irq dropped without software");
  a_pirq_hold: assert property ($fell(periodic_irq) |->
    $past(pw_acc))
    else $error("periodic irq dropped without software");
  a_flag_clear: assert property (s_clr_both |=>
    !counter_irq || ev_any)
    else $error("counter irq stayed after clearing both flags");
endmodule

bind rtcpit_top rtcpit_top_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .counter_irq(counter_irq), .periodic_irq(periodic_irq),
  .wrap_event(wrap_event), .match_event(match_event),
  .interval_event(interval_event)
);

/* File: tb/test_rtc_periodic_interrupt_timer.sv */
// self-checking bench for the rtc counter and interval timer block
`timescale 1ns/1ns
`include "rtcpit_defines.svh"
module test_rtc_periodic_interrupt_timer;
  import rtcpit_pkg::*;
  logic          pclk = 1'h0;
  logic          presetn = 1'h0;
  logic          psel = 1'h0;
  logic          penable = 1'h0;
  logic          pwrite = 1'h0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    osc_r = 4'h0;
  rtcpit_sleep_t sleep_mode = RTCPIT_ACTIVE;
  logic          counter_irq;
  logic          periodic_irq;
  logic          wrap_event;
  logic          match_event;
  logic [7:0]    interval_event;
  logic [33:0]   exp_q[$];
  logic [33:0]   note;
  logic [31:0]   q;
  logic [31:0]   d;
  logic          ok;
  int            err_count = 0;
  int            n_tests = 0;
  int            seed = 69097;
  int            n;
  localparam logic [5:0] RI [6] = '{`RTCPIT_IDX_TEMP, `RTCPIT_IDX_DBG,
    `RTCPIT_IDX_PDBG, `RTCPIT_IDX_PIRQEN, `RTCPIT_IDX_IRQEN,
    `RTCPIT_IDX_STATUS};
  localparam logic [7:0] RM [6] = '{8'hFF, `RTCPIT_ONEBIT_WMASK,
    `RTCPIT_ONEBIT_WMASK, `RTCPIT_ONEBIT_WMASK, `RTCPIT_IRQEN_WMASK, 8'h00};

  rtcpit_top #(.CNT_W(16), .PSC_W(15)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .low_power_oscillator_clk(osc_r[2]), .ext_clk_pin(osc_r[3]),
    .sleep_mode(sleep_mode), .cpu_halted(1'h0),
    .counter_irq(counter_irq), .periodic_irq(periodic_irq),
    .wrap_event(wrap_event), .match_event(match_event),
    .interval_event(interval_event)
  );

  always #5 pclk = ~pclk;
  // oscillator at an eighth of pclk, pin at a sixteenth: both stay inside
  // the synchroniser's limit
  always @(posedge pclk) osc_r <= osc_r + 4'h1;

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] v);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) begin
      err_count++;
      final_report();
    end else begin
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask

  // e holds care bit, error bit and data
  task automatic rd(input logic [5:0] i, input logic [33:0] e);
    exp_q.push_back(e);
    apb(1'h0, i, 32'h0);
  endtask

  task automatic poll(input logic [5:0] i);
    int k;
    k = 0;
    do begin
      rd(i, 34'h0);
      k++;
    end while (q[7:0] !== 8'h00 && k < 40);
    if (k == 40) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic wait_sig(input int s, input int lim, output logic hit);
    int k;
    hit = 1'h0;
    for (k = 0; k < lim && !hit; k++) begin
      @(posedge pclk);
      hit = (s == 0) ? wrap_event : (s == 1) ? match_event :
        (s == 2) ? periodic_irq : interval_event[7];
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'h1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[33]) chk({1'h1, pslverr, prdata}, note);
    end
  end

  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(`RTCPIT_IDX_CTRL, {2'h2, 32'h0});
    rd(`RTCPIT_IDX_TOP, {2'h2, 16'h0, `RTCPIT_TOP_RST});
    rd(`RTCPIT_IDX_SRC, {2'h2, 32'h0});
    rd(6'h06, {2'h3, 32'h0});
    apb(1'h1, 6'h06, 32'hFF);
    for (n = 0; n < 6; n++) begin
      d = $random(seed);
      apb(1'h1, RI[n], d);
      rd(RI[n], {2'h2, 24'h0, d[7:0] & RM[n]});
    end
    apb(1'h1, `RTCPIT_IDX_TOP, 32'h5);
    rd(`RTCPIT_IDX_STATUS, {2'h2, 32'h4});
    poll(`RTCPIT_IDX_STATUS);
    apb(1'h1, `RTCPIT_IDX_CMP, 32'h3);
    poll(`RTCPIT_IDX_STATUS);
    apb(1'h1, `RTCPIT_IDX_IRQEN, 32'h2);
    apb(1'h1, `RTCPIT_IDX_CTRL, 32'h1);
    poll(`RTCPIT_IDX_STATUS);
    wait_sig(0, 400, ok);
    chk({33'h0, ok}, 34'h1);
    // stop first: a running count would set match again mid-check
    apb(1'h1, `RTCPIT_IDX_CTRL, 32'h0);
    poll(`RTCPIT_IDX_STATUS);
    rd(`RTCPIT_IDX_FLAGS, {2'h2, 32'h3});
    chk({33'h0, counter_irq}, 34'h1);
    apb(1'h1, `RTCPIT_IDX_FLAGS, 32'h2);
    rd(`RTCPIT_IDX_FLAGS, {2'h2, 32'h1});
    chk({33'h0, counter_irq}, 34'h0);
    apb(1'h1, `RTCPIT_IDX_FLAGS, 32'h0);
    rd(`RTCPIT_IDX_FLAGS, {2'h2, 32'h1});
    apb(1'h1, `RTCPIT_IDX_FLAGS, 32'h3);
    apb(1'h1, `RTCPIT_IDX_CNT, 32'h2);
    poll(`RTCPIT_IDX_STATUS);
    rd(`RTCPIT_IDX_CNT, {2'h2, 32'h2});
    sleep_mode <= RTCPIT_STANDBY;
    apb(1'h1, `RTCPIT_IDX_CTRL, 32'h1);
    poll(`RTCPIT_IDX_STATUS);
    repeat (200) @(posedge pclk);
    rd(`RTCPIT_IDX_CNT, {2'h2, 32'h2});
    sleep_mode <= RTCPIT_IDLE;
    wait_sig(1, 400, ok);
    chk({33'h0, ok}, 34'h1);
    wait_sig(0, 400, ok);
    chk({33'h0, ok}, 34'h1);
    sleep_mode <= RTCPIT_STANDBY;
    apb(1'h1, `RTCPIT_IDX_CTRL, 32'h81);
    poll(`RTCPIT_IDX_STATUS);
    wait_sig(0, 400, ok);
    chk({33'h0, ok}, 34'h1);
    apb(1'h1, `RTCPIT_IDX_PIRQEN, 32'h1);
    apb(1'h1, `RTCPIT_IDX_PCTRL, 32'h9);
    rd(`RTCPIT_IDX_PSTATUS, {2'h2, 32'h1});
    poll(`RTCPIT_IDX_PSTATUS);
    wait_sig(2, 400, ok);
    chk({33'h0, ok}, 34'h1);
    rd(`RTCPIT_IDX_PFLAG, {2'h2, 32'h1});
    wait_sig(3, 1200, ok);
    chk({33'h0, ok}, 34'h1);
    apb(1'h1, `RTCPIT_IDX_PCTRL, 32'h0);
    poll(`RTCPIT_IDX_PSTATUS);
    apb(1'h1, `RTCPIT_IDX_PFLAG, 32'h1);
    rd(`RTCPIT_IDX_PFLAG, {2'h2, 32'h0});
    chk({33'h0, periodic_irq}, 34'h0);
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      if (interval_event !== 8'h00) n++;
    end
    chk(34'(n), 34'h0);
    // reserved source gives no ticks, so a control write stays pending
    apb(1'h1, `RTCPIT_IDX_SRC, 32'h2);
    apb(1'h1, `RTCPIT_IDX_CTRL, 32'h0);
    repeat (100) @(posedge pclk);
    rd(`RTCPIT_IDX_STATUS, {2'h2, 32'h1});
    // the pin already toggles before it is chosen
    apb(1'h1, `RTCPIT_IDX_SRC, 32'h3);
    poll(`RTCPIT_IDX_STATUS);
    rd(`RTCPIT_IDX_SRC, {2'h2, 32'h3});
    final_report();
  end
endmodule
